// ==== src/fspo_pkg.sv ====
package fspo_pkg;
    localparam logic [3:0]  REG_OPTION         = 4'h0;
    localparam logic [3:0]  REG_CONFIG         = 4'h1;
    localparam logic [3:0]  REG_PROTECT        = 4'h2;
    localparam logic [3:0]  REG_STATUS         = 4'h3;
    localparam int          OPT_BACKDOOR_BIT   = 7;
    localparam int          OPT_REDIR_DIS_BIT  = 6;
    localparam int          CFG_KEY_WRITE_BIT  = 5;
    localparam int          STAT_VIOL_BIT      = 5;
    localparam logic [7:0]  OPTION_MASK        = 8'hc3;
    localparam logic [7:0]  OPTION_RESET       = 8'h40;
    localparam logic [1:0]  SEC_UNSECURED      = 2'h2;
    localparam logic [5:0]  PROTECT_NONE       = 6'h3f;
    localparam logic [5:0]  PROTECT_FULL       = 6'h18;
    localparam logic [5:0]  PROTECT_RESET      = 6'h00;
    localparam logic [16:0] SECTOR_PAIR_BYTES  = 17'h00600;
    localparam logic [16:0] MEM_TOP            = 17'h10000;
    localparam logic [15:0] KEY_BASE_ADDR      = 16'hffb0;
    localparam logic [15:0] KEY_ADDR_MASK      = 16'hfff8;
    localparam logic [3:0]  KEY_BYTES          = 4'h8;

    typedef enum logic [0:0] {
        FSPO_LOAD,
        FSPO_RUN
    } fspo_phase_t;
endpackage

// ==== src/fspo_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module fspo_top (
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_write,
    input  wire logic        i_reg_read,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic [7:0]  i_stored_option_byte,
    input  wire logic [7:0]  i_stored_protect_byte,
    input  wire logic [63:0] i_stored_backdoor_key,
    input  wire logic        i_cpu_write,
    input  wire logic [15:0] i_cpu_addr,
    input  wire logic [7:0]  i_cpu_wdata,
    input  wire logic        i_cpu_from_debug,
    output logic             o_cmd_start,
    output logic      [15:0] o_cmd_addr,
    output logic      [7:0]  o_cmd_data,
    input  wire logic        i_pe_request,
    input  wire logic [15:0] i_pe_addr,
    input  wire logic        i_pe_mass,
    output logic             o_pe_accept,
    output logic             o_pe_refuse,
    input  wire logic        i_blank_check_pass,
    input  wire logic        i_mem_read,
    input  wire logic        i_mem_read_untrusted,
    output logic             o_mem_read_grant,
    output logic             o_mem_read_deny,
    output logic             o_secured,
    output logic             o_vector_redirect_enable,
    output logic             o_protect_any,
    output logic      [16:0] o_protect_base
);
    import fspo_pkg::*;

    typedef struct packed {
        fspo_phase_t phase;
        logic [7:0]  option;
        logic        key_write_enable;
        logic [5:0]  protect_select;
        logic        violation;
        logic [63:0] key;
        logic [3:0]  key_count;
        logic        key_seq_err;
        logic [7:0]  rdata;
        logic        cmd_start;
        logic [15:0] cmd_addr;
        logic [7:0]  cmd_data;
        logic        pe_accept;
        logic        pe_refuse;
        logic        read_grant;
        logic        read_deny;
        logic        secured;
        logic        redirect_en;
        logic        protect_any;
        logic [16:0] protect_base;
    } fspo_state_t;

    localparam fspo_state_t STATE_RESET = '{
        phase:            FSPO_LOAD,
        option:           OPTION_RESET,
        key_write_enable: 1'b0,
        protect_select:   PROTECT_RESET,
        violation:        1'b0,
        key:              64'h0,
        key_count:        4'h0,
        key_seq_err:      1'b0,
        rdata:            8'h00,
        cmd_start:        1'b0,
        cmd_addr:         16'h0000,
        cmd_data:         8'h00,
        pe_accept:        1'b0,
        pe_refuse:        1'b0,
        read_grant:       1'b0,
        read_deny:        1'b0,
        secured:          1'b1,
        redirect_en:      1'b0,
        protect_any:      1'b1,
        protect_base:     17'h00000
    };

    fspo_state_t state_reg;
    fspo_state_t state_next;

    // Codes at or below the full threshold all guard the whole map
    function automatic logic [5:0] effective_select(input logic [5:0] sel);
        effective_select = (sel < PROTECT_FULL) ? PROTECT_FULL : sel;
    endfunction

    // None selected gives the top address itself, so nothing compares above it
    function automatic logic [16:0] protect_base_of(input logic [5:0] sel);
        logic [16:0] steps;
        logic [16:0] span;
        steps = {11'h000, PROTECT_NONE - effective_select(sel)};
        span  = steps * SECTOR_PAIR_BYTES;
        if (sel <= PROTECT_FULL) begin
            protect_base_of = 17'h00000;
        end else begin
            protect_base_of = MEM_TOP - span;
        end
    endfunction

    logic        key_range_hit;
    logic        key_match;
    logic        pe_blocked;
    logic [2:0]  key_index;

    always_comb begin
        state_next = state_reg;
        key_index  = i_cpu_addr[2:0];
        key_range_hit = (i_cpu_addr & KEY_ADDR_MASK) == KEY_BASE_ADDR;
        key_match = state_reg.option[OPT_BACKDOOR_BIT]
                    && (state_reg.key_count == KEY_BYTES)
                    && !state_reg.key_seq_err
                    && (state_reg.key == i_stored_backdoor_key);
        if (i_pe_mass) begin
            pe_blocked = state_reg.protect_select != PROTECT_NONE;
        end else begin
            pe_blocked = {1'b0, i_pe_addr} >= state_reg.protect_base;
        end
        state_next.rdata      = 8'h00;
        state_next.cmd_start  = 1'b0;
        state_next.pe_accept  = 1'b0;
        state_next.pe_refuse  = 1'b0;
        state_next.read_grant = 1'b0;
        state_next.read_deny  = 1'b0;
        unique case (state_reg.phase)
            FSPO_LOAD: begin
                // Copy lands on the first edge after release; the async reset may only load constants
                state_next.option         = i_stored_option_byte & OPTION_MASK;
                state_next.protect_select = i_stored_protect_byte[5:0];
                state_next.phase          = FSPO_RUN;
            end
            FSPO_RUN: begin
                if (i_reg_write) begin
                    unique case (i_reg_addr)
                        REG_CONFIG: begin
                            state_next.key_write_enable = i_reg_wdata[CFG_KEY_WRITE_BIT];
                            if (state_reg.key_write_enable && !i_reg_wdata[CFG_KEY_WRITE_BIT]) begin
                                if (key_match) begin
                                    state_next.option[1:0] = SEC_UNSECURED;
                                end
                                state_next.key_count   = 4'h0;
                                state_next.key_seq_err = 1'b0;
                            end
                            if (!state_reg.key_write_enable && i_reg_wdata[CFG_KEY_WRITE_BIT]) begin
                                state_next.key_count   = 4'h0;
                                state_next.key_seq_err = 1'b0;
                            end
                        end
                        REG_PROTECT: begin
                            if (effective_select(i_reg_wdata[5:0])
                                <= effective_select(state_reg.protect_select)) begin
                                state_next.protect_select = i_reg_wdata[5:0];
                            end
                        end
                        REG_STATUS: begin
                            if (i_reg_wdata[STAT_VIOL_BIT]) begin
                                state_next.violation = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (i_cpu_write && key_range_hit) begin
                    if (state_reg.key_write_enable) begin
                        // Debug-sourced writes are dropped so a probe cannot feed the key
                        if (!i_cpu_from_debug) begin
                            if ((state_reg.key_count < KEY_BYTES)
                                && ({1'b0, key_index} == state_reg.key_count)) begin
                                state_next.key[8*key_index +: 8] = i_cpu_wdata;
                                state_next.key_count = state_reg.key_count + 4'h1;
                            end else begin
                                state_next.key_seq_err = 1'b1;
                            end
                        end
                    end else begin
                        state_next.cmd_start = 1'b1;
                        state_next.cmd_addr  = i_cpu_addr;
                        state_next.cmd_data  = i_cpu_wdata;
                    end
                end
                if (i_pe_request) begin
                    if (pe_blocked) begin
                        state_next.pe_refuse = 1'b1;
                        state_next.violation = 1'b1;
                    end else begin
                        state_next.pe_accept = 1'b1;
                    end
                end
                if (i_blank_check_pass) begin
                    state_next.option[1:0] = SEC_UNSECURED;
                end
                if (i_mem_read) begin
                    if (state_reg.secured && i_mem_read_untrusted) begin
                        state_next.read_deny = 1'b1;
                    end else begin
                        state_next.read_grant = 1'b1;
                    end
                end
                if (i_reg_read) begin
                    unique case (i_reg_addr)
                        REG_OPTION: begin
                            state_next.rdata = state_reg.option & OPTION_MASK;
                        end
                        REG_CONFIG: begin
                            state_next.rdata = {2'h0, state_reg.key_write_enable, 5'h00};
                        end
                        REG_PROTECT: begin
                            state_next.rdata = {2'h0, state_reg.protect_select};
                        end
                        REG_STATUS: begin
                            state_next.rdata = {2'h0, state_reg.violation, 5'h00};
                        end
                        default: begin
                            state_next.rdata = 8'h00;
                        end
                    endcase
                end
            end
        endcase
        state_next.secured      = state_next.option[1:0] != SEC_UNSECURED;
        state_next.redirect_en  = !state_next.option[OPT_REDIR_DIS_BIT];
        state_next.protect_any  = state_next.protect_select != PROTECT_NONE;
        state_next.protect_base = protect_base_of(state_next.protect_select);
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_reg_rdata              = state_reg.rdata;
    assign o_cmd_start              = state_reg.cmd_start;
    assign o_cmd_addr               = state_reg.cmd_addr;
    assign o_cmd_data               = state_reg.cmd_data;
    assign o_pe_accept              = state_reg.pe_accept;
    assign o_pe_refuse              = state_reg.pe_refuse;
    assign o_mem_read_grant         = state_reg.read_grant;
    assign o_mem_read_deny          = state_reg.read_deny;
    assign o_secured                = state_reg.secured;
    assign o_vector_redirect_enable = state_reg.redirect_en;
    assign o_protect_any            = state_reg.protect_any;
    assign o_protect_base           = state_reg.protect_base;
endmodule
`default_nettype wire

// ==== dv/fspo_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module fspo_chk (
    input wire logic        i_clock,
    input wire logic        i_reset,
    input wire logic        i_mem_read,
    input wire logic        i_mem_read_untrusted,
    input wire logic        o_mem_read_grant,
    input wire logic        o_mem_read_deny,
    input wire logic        o_secured,
    input wire logic        i_blank_check_pass,
    input wire logic        i_pe_request,
    input wire logic [15:0] i_pe_addr,
    input wire logic        i_pe_mass,
    input wire logic        o_pe_accept,
    input wire logic        o_pe_refuse,
    input wire logic        o_protect_any,
    input wire logic [16:0] o_protect_base,
    input wire logic        o_vector_redirect_enable
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);
    chk_read_deny: assert property (i_mem_read && i_mem_read_untrusted && o_secured
        |=> o_mem_read_deny && !o_mem_read_grant) else $error("read not denied");
    chk_read_grant: assert property (i_mem_read && !(i_mem_read_untrusted && o_secured)
        |=> o_mem_read_grant && !o_mem_read_deny) else $error("read not granted");
    chk_blank_unsec: assert property (i_blank_check_pass |=> !o_secured)
        else $error("blank pass kept security");
    chk_mass_refuse: assert property (i_pe_request && i_pe_mass && o_protect_any
        |=> o_pe_refuse && !o_pe_accept) else $error("mass erase not refused");
    chk_pe_refuse: assert property (i_pe_request && {1'b0, i_pe_addr} >= o_protect_base
        |=> o_pe_refuse && !o_pe_accept) else $error("protected access not refused");
    chk_pe_accept: assert property (i_pe_request && !i_pe_mass
        && {1'b0, i_pe_addr} < o_protect_base |=> o_pe_accept) else $error("access refused");
    chk_unsec_held: assert property (!o_secured |=> !o_secured)
        else $error("security came back before reset");
    chk_redir_fixed: assert property (!$past(i_reset) && !$past(i_reset, 2)
        |-> $stable(o_vector_redirect_enable)) else $error("option changed after load");
    chk_any_base: assert property (o_protect_any == (o_protect_base != 17'h10000))
        else $error("protect flag and base disagree");
    cov_blank: cover property (i_blank_check_pass ##1 !o_secured);
    cov_deny: cover property (o_mem_read_deny);
    cov_refuse: cover property (o_pe_refuse);
endmodule
bind fspo_top fspo_chk u_fspo_chk (.i_clock, .i_reset, .i_mem_read, .i_mem_read_untrusted,
    .o_mem_read_grant, .o_mem_read_deny, .o_secured, .i_blank_check_pass, .i_pe_request,
    .i_pe_addr, .i_pe_mass, .o_pe_accept, .o_pe_refuse, .o_protect_any, .o_protect_base,
    .o_vector_redirect_enable);
`default_nettype wire

// ==== dv/test_flash_security_protection_options.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_flash_security_protection_options;
    import fspo_pkg::*;
    logic        i_clock = 0;
    logic        i_reset = 1;
    logic [3:0]  ra = 0;
    logic [7:0]  wd = 0, rdat, so = 0, sp = 0, cd = 0, cmd;
    logic        wr = 0, rd = 0, cw = 0, dbg = 0, pr = 0, pm = 0, bp = 0, mr = 0, mu = 0;
    logic        cst, pacc, pref, mg, mdn, sec, red, pany;
    logic [15:0] ca = 0, pa = 0, cma;
    logic [16:0] base;
    logic [63:0] key = 0;
    logic [31:0] lf = 32'h1015bdc7;
    int          n_errors = 0, tests_run = 0, cyc = 0;
    fspo_top u_fspo_top (.i_clock, .i_reset, .i_reg_addr(ra), .i_reg_wdata(wd),
        .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdat), .i_stored_option_byte(so),
        .i_stored_protect_byte(sp), .i_stored_backdoor_key(key), .i_cpu_write(cw),
        .i_cpu_addr(ca), .i_cpu_wdata(cd), .i_cpu_from_debug(dbg), .o_cmd_start(cst),
        .o_cmd_addr(cma), .o_cmd_data(cmd), .i_pe_request(pr), .i_pe_addr(pa), .i_pe_mass(pm),
        .o_pe_accept(pacc), .o_pe_refuse(pref), .i_blank_check_pass(bp), .i_mem_read(mr),
        .i_mem_read_untrusted(mu), .o_mem_read_grant(mg), .o_mem_read_deny(mdn),
        .o_secured(sec), .o_vector_redirect_enable(red), .o_protect_any(pany),
        .o_protect_base(base));
    always #2 i_clock = ~i_clock;
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Select values at or below the full-map code all cover the whole map
    function automatic logic [16:0] bexp(logic [5:0] v);
        if (v <= 6'h18)
            return 17'h00000;
        return 17'h10000 - 17'(6'h3f - v) * 17'h00600;
    endfunction
    task automatic close_out();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic cmp(logic [16:0] got, logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rst(logic [7:0] o, logic [5:0] p);
        @(posedge i_clock);
        i_reset <= 1;
        so <= o;
        sp <= {2'b00, p};
        repeat (2) @(posedge i_clock);
        i_reset <= 0;
        @(posedge i_clock);
    endtask
    task automatic wreg(logic [3:0] a, logic [7:0] d);
        @(posedge i_clock);
        ra <= a;
        wd <= d;
        wr <= 1;
        @(posedge i_clock);
        wr <= 0;
    endtask
    task automatic rreg(logic [3:0] a, logic [7:0] e);
        @(posedge i_clock);
        ra <= a;
        rd <= 1;
        @(posedge i_clock);
        rd <= 0;
        #1 cmp(17'(rdat), 17'(e));
    endtask
    task automatic cwr(logic [15:0] a, logic [7:0] d, logic g);
        @(posedge i_clock);
        ca <= a;
        cd <= d;
        dbg <= g;
        cw <= 1;
        @(posedge i_clock);
        cw <= 0;
    endtask
    task automatic pe(logic [15:0] a, logic m, logic r);
        @(posedge i_clock);
        pa <= a;
        pm <= m;
        pr <= 1;
        @(posedge i_clock);
        pr <= 0;
        #1 cmp(17'({pacc, pref}), 17'({!r, r}));
    endtask
    task automatic memr(logic u, logic d);
        @(posedge i_clock);
        mu <= u;
        mr <= 1;
        @(posedge i_clock);
        mr <= 0;
        #1 cmp(17'({mg, mdn}), 17'({!d, d}));
    endtask
    // Debug writes go first so that, if they were counted, they would poison the attempt
    task automatic keyseq(logic [7:0] x);
        wreg(REG_CONFIG, 8'h20);
        for (int n = 0; n < 8; n++)
            cwr(16'hffb0 + 16'(n), ~key[8*n +: 8], 1);
        for (int n = 0; n < 8; n++)
            cwr(16'hffb0 + 16'(n), key[8*n +: 8] ^ (n == 3 ? x : 8'h00), 0);
        wreg(REG_CONFIG, 8'h00);
        @(posedge i_clock);
    endtask
    initial begin
        for (int n = 0; n < 8; n++) begin
            lf = nx(lf);
            key[8*n +: 8] = lf[7:0];
        end
        for (int k = 0; k < 4; k++) begin
            rst({1'b0, k[0], 4'h0, 2'(k)}, 6'h3f);
            #1 cmp(17'(sec), 17'(k != 2));
            cmp(17'(pany), 17'h0);
            cmp(17'(red), 17'(!k[0]));
            rreg(REG_OPTION, {1'b0, k[0], 4'h0, 2'(k)});
        end
        pe(16'h0000, 1, 0);
        keyseq(8'h00);
        #1 cmp(17'(sec), 17'h1);
        @(posedge i_clock);
        bp <= 1;
        @(posedge i_clock);
        bp <= 0;
        #1 cmp(17'(sec), 17'h0);
        rreg(REG_OPTION, 8'h42);
        $display("security code and option tests done");
        rst(8'h80, 6'h3c);
        #1 cmp(base, 17'h0ee00);
        cmp(17'(pany), 17'h1);
        rreg(REG_CONFIG, 8'h00);
        rreg(4'h7, 8'h00);
        wreg(REG_OPTION, 8'hff);
        rreg(REG_OPTION, 8'h80);
        wreg(REG_PROTECT, 8'h3d);
        rreg(REG_PROTECT, 8'h3c);
        wreg(REG_PROTECT, 8'hfa);
        rreg(REG_PROTECT, 8'h3a);
        cmp(base, bexp(6'h3a));
        pe(16'(bexp(6'h3a) - 17'h00001), 0, 0);
        pe(16'(bexp(6'h3a)), 0, 1);
        for (int n = 0; n < 6; n++) begin
            lf = nx(lf);
            pe(lf[15:0], 0, {1'b0, lf[15:0]} >= bexp(6'h3a));
        end
        pe(16'h0000, 1, 1);
        rreg(REG_STATUS, 8'h20);
        wreg(REG_STATUS, 8'h20);
        rreg(REG_STATUS, 8'h00);
        $display("protection tests done");
        memr(1, 1);
        memr(0, 0);
        cwr(16'hffb5, lf[7:0], 0);
        #1 cmp({cst, cma}, {1'b1, 16'hffb5});
        cmp(17'(cmd), 17'(lf[7:0]));
        keyseq(8'h01);
        cmp(17'(sec), 17'h1);
        // An out-of-order byte poisons the attempt even if the right bytes follow
        wreg(REG_CONFIG, 8'h20);
        cwr(16'hffb1, key[15:8], 0);
        for (int n = 0; n < 8; n++)
            cwr(16'hffb0 + 16'(n), key[8*n +: 8], 0);
        wreg(REG_CONFIG, 8'h00);
        @(posedge i_clock);
        cmp(17'(sec), 17'h1);
        keyseq(8'h00);
        cmp(17'(sec), 17'h0);
        rreg(REG_OPTION, 8'h82);
        memr(1, 0);
        wreg(REG_PROTECT, 8'h05);
        rreg(REG_PROTECT, 8'h05);
        cmp(base, 17'h00000);
        $display("key and read gate tests done");
        close_out();
    end
endmodule
`default_nettype wire
